// ### include/grs_chk_if.sv
// coordinate and window values out to the check unit, check results back
`timescale 1ns/100ps
interface grs_chk_if;
    logic [31:0] cx [4];
    logic [31:0] cy [4];
    logic [31:0] win_min;
    logic [31:0] win_max;
    logic [7:0] xclip;
    logic [7:0] yclip;
    logic [7:0] oor;
    logic [3:0] hv_less;
    logic [3:0] hv_greater;
    logic [3:0] vv_less;
    logic [3:0] vv_greater;
    modport regs (output cx, cy, win_min, win_max,
                  input xclip, yclip, oor, hv_less, hv_greater, vv_less, vv_greater);
    modport chk (input cx, cy, win_min, win_max,
                 output xclip, yclip, oor, hv_less, hv_greater, vv_less, vv_greater);
endinterface

// ### include/grs_pkg.sv
// register indices, field positions and reset values of the graphics register set
package grs_pkg;
    localparam int GRS_AW = 6;
    localparam int GRS_DW = 32;
    localparam int GRS_IRQ_W = 8;
    localparam int GRS_NVTX = 4;
    localparam int GRS_CW = 16;
    // register indices (host access index, one 32-bit word each)
    localparam logic [5:0] GRS_SYSCONFIG = 6'h00;
    localparam logic [5:0] GRS_INT_FLAG = 6'h01;
    localparam logic [5:0] GRS_INT_EN = 6'h02;
    localparam logic [5:0] GRS_COORD_BASE = 6'h03;
    localparam logic [5:0] GRS_COORD_LAST = 6'h0A;
    localparam logic [5:0] GRS_STATUS = 6'h0B;
    localparam logic [5:0] GRS_OOR = 6'h0C;
    localparam logic [5:0] GRS_CINDEX = 6'h0D;
    localparam logic [5:0] GRS_WOFF_X = 6'h0E;
    localparam logic [5:0] GRS_WOFF_Y = 6'h0F;
    localparam logic [5:0] GRS_PW_LOW = 6'h10;
    localparam logic [5:0] GRS_PW_HIGH = 6'h11;
    localparam logic [5:0] GRS_XCLIP = 6'h12;
    localparam logic [5:0] GRS_YCLIP = 6'h13;
    localparam logic [5:0] GRS_HV_LESS = 6'h14;
    localparam logic [5:0] GRS_HV_GREATER = 6'h15;
    localparam logic [5:0] GRS_VV_LESS = 6'h16;
    localparam logic [5:0] GRS_VV_GREATER = 6'h17;
    localparam logic [5:0] GRS_COLOR_BASE = 6'h18;
    localparam logic [5:0] GRS_COLOR_LAST = 6'h1B;
    localparam logic [5:0] GRS_PMASK = 6'h1C;
    localparam logic [5:0] GRS_DRAW_CTL = 6'h1D;
    localparam logic [5:0] GRS_TILE_X = 6'h1E;
    localparam logic [5:0] GRS_TILE_Y = 6'h1F;
    localparam logic [5:0] GRS_BYTE_PIX = 6'h20;
    localparam logic [5:0] GRS_WIN_MIN = 6'h21;
    localparam logic [5:0] GRS_WIN_MAX = 6'h22;
    localparam logic [5:0] GRS_RASTER = 6'h23;
    // status word bit positions
    localparam int GRS_ST_BUSY = 0;
    localparam int GRS_ST_XCLIP = 1;
    localparam int GRS_ST_YCLIP = 2;
    localparam int GRS_ST_OOR = 3;
    // window words: x in the upper half, y in the lower half
    localparam int GRS_WX_LSB = 16;
    localparam int GRS_WY_LSB = 0;
    // reset values
    localparam logic [31:0] GRS_SYSCONFIG_RST = 32'h0000_0000;
    localparam logic [7:0] GRS_INT_RST = 8'h00;
    localparam logic [31:0] GRS_ZERO = 32'h0000_0000;
endpackage

// ### rtl/grs_coord_check.sv
// clip, range and vertex relation checks on the four device vertices
`timescale 1ns/100ps
module grs_coord_check
    import grs_pkg::*;
(
    grs_chk_if.chk chk
);
    logic signed [15:0] wxl;
    logic signed [15:0] wxh;
    logic signed [15:0] wyl;
    logic signed [15:0] wyh;

    assign wxl = chk.win_min[GRS_WX_LSB +: GRS_CW];
    assign wxh = chk.win_max[GRS_WX_LSB +: GRS_CW];
    assign wyl = chk.win_min[GRS_WY_LSB +: GRS_CW];
    assign wyh = chk.win_max[GRS_WY_LSB +: GRS_CW];

    for (genvar v = 0; v < GRS_NVTX; v++) begin : g_vtx
        localparam int NX = (v + 1) % GRS_NVTX;
        logic signed [15:0] x;
        logic signed [15:0] y;
        logic signed [15:0] xn;
        logic signed [15:0] yn;
        assign x = chk.cx[v][15:0];
        assign y = chk.cy[v][15:0];
        assign xn = chk.cx[NX][15:0];
        assign yn = chk.cy[NX][15:0];
        // below window in bit 2v, above in bit 2v+1
        assign chk.xclip[2*v] = x < wxl;
        assign chk.xclip[2*v+1] = x > wxh;
        assign chk.yclip[2*v] = y < wyl;
        assign chk.yclip[2*v+1] = y > wyh;
        // value not a sign extension of its low 16 bits
        assign chk.oor[2*v] = !(&chk.cx[v][31:15] || !(|chk.cx[v][31:15]));
        assign chk.oor[2*v+1] = !(&chk.cy[v][31:15] || !(|chk.cy[v][31:15]));
        // each vertex against the next one round the quad
        assign chk.hv_less[v] = x < xn;
        assign chk.hv_greater[v] = x > xn;
        assign chk.vv_less[v] = y < yn;
        assign chk.vv_greater[v] = y > yn;
    end
endmodule // grs_coord_check

// ### rtl/grs_regs.sv
// software-visible register set of the 2-d drawing engine
`timescale 1ns/100ps
module grs_regs
    import grs_pkg::*;
#(
    parameter int IRQ_W = GRS_IRQ_W
) (
    // clock and host reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // host register access
    input wire logic hst_wr_i,
    input wire logic hst_rd_i,
    input wire logic [GRS_AW-1:0] hst_addr_i,
    input wire logic [GRS_DW-1:0] hst_wdata_i,
    output logic [GRS_DW-1:0] hst_rdata_o,
    output logic hst_rvalid_o,
    // engine side
    input wire logic mode_change_i,
    input wire logic engine_busy_i,
    input wire logic [IRQ_W-1:0] int_event_i,
    input wire logic pix_load_i,
    input wire logic [GRS_DW-1:0] pix_data_i,
    // interrupt and control outputs
    output logic irq_o,
    output logic [GRS_DW-1:0] sysconfig_o,
    output logic [GRS_DW-1:0] pmask_o,
    output logic [GRS_DW-1:0] draw_ctl_o,
    output logic [1:0] cindex_o
);
    grs_chk_if chk_if ();

    // reset group
    logic [GRS_DW-1:0] sysconfig;
    logic [IRQ_W-1:0] int_flag;
    logic [IRQ_W-1:0] int_en;
    logic [GRS_DW-1:0] rd_data;
    logic rd_valid;
    logic irq;
    logic [GRS_DW-1:0] next_sysconfig;
    logic [IRQ_W-1:0] next_int_flag;
    logic [IRQ_W-1:0] next_int_en;
    logic [GRS_DW-1:0] next_rd_data;
    logic next_rd_valid;
    logic next_irq;

    // drawing state, left alone by reset
    logic [GRS_DW-1:0] coord [8];
    logic [GRS_DW-1:0] color [4];
    logic [GRS_DW-1:0] pmask;
    logic [GRS_DW-1:0] draw_ctl;
    logic [GRS_DW-1:0] tile_x;
    logic [GRS_DW-1:0] tile_y;
    logic [GRS_DW-1:0] byte_pixel_leftover;
    logic [GRS_DW-1:0] win_min;
    logic [GRS_DW-1:0] win_max;
    logic [GRS_DW-1:0] woff_x;
    logic [GRS_DW-1:0] woff_y;
    logic [GRS_DW-1:0] raster;
    logic [1:0] cindex;
    logic [7:0] oor;
    logic [7:0] xclip;
    logic [7:0] yclip;
    logic [3:0] hv_less;
    logic [3:0] hv_greater;
    logic [3:0] vv_less;
    logic [3:0] vv_greater;
    logic busy;
    logic [GRS_DW-1:0] next_coord [8];
    logic [GRS_DW-1:0] next_color [4];
    logic [GRS_DW-1:0] next_pmask;
    logic [GRS_DW-1:0] next_draw_ctl;
    logic [GRS_DW-1:0] next_tile_x;
    logic [GRS_DW-1:0] next_tile_y;
    logic [GRS_DW-1:0] next_byte_pixel_leftover;
    logic [GRS_DW-1:0] next_win_min;
    logic [GRS_DW-1:0] next_win_max;
    logic [GRS_DW-1:0] next_woff_x;
    logic [GRS_DW-1:0] next_woff_y;
    logic [GRS_DW-1:0] next_raster;
    logic [1:0] next_cindex;

    logic [5:0] coord_off;
    logic [5:0] color_off;
    logic coord_hit;
    logic color_hit;
    logic [GRS_DW-1:0] status_word;
    logic [GRS_DW-1:0] rd_mux;

    assign coord_off = hst_addr_i - GRS_COORD_BASE;
    assign color_off = hst_addr_i - GRS_COLOR_BASE;
    assign coord_hit = hst_addr_i >= GRS_COORD_BASE && hst_addr_i <= GRS_COORD_LAST;
    assign color_hit = hst_addr_i >= GRS_COLOR_BASE && hst_addr_i <= GRS_COLOR_LAST;

    for (genvar i = 0; i < GRS_NVTX; i++) begin : g_chk
        assign chk_if.cx[i] = coord[2*i];
        assign chk_if.cy[i] = coord[2*i+1];
    end
    assign chk_if.win_min = win_min;
    assign chk_if.win_max = win_max;

    grs_coord_check u_check (
        .chk (chk_if.chk)
    );

    // status is live, so it never needs a reset value
    always_comb begin
        status_word = GRS_ZERO;
        status_word[GRS_ST_BUSY] = busy;
        status_word[GRS_ST_XCLIP] = |xclip;
        status_word[GRS_ST_YCLIP] = |yclip;
        status_word[GRS_ST_OOR] = |oor;
    end

    // read mux; unmapped indices read zero
    always_comb begin
        rd_mux = GRS_ZERO;
        if (coord_hit) begin
            rd_mux = coord[coord_off[2:0]];
        end else if (color_hit) begin
            rd_mux = color[color_off[1:0]];
        end else begin
            case (hst_addr_i)
                GRS_SYSCONFIG: rd_mux = sysconfig;
                GRS_INT_FLAG: rd_mux = {{(GRS_DW-IRQ_W){1'b0}}, int_flag};
                GRS_INT_EN: rd_mux = {{(GRS_DW-IRQ_W){1'b0}}, int_en};
                GRS_STATUS: rd_mux = status_word;
                GRS_OOR: rd_mux = {24'h00_0000, oor};
                GRS_CINDEX: rd_mux = {30'h0000_0000, cindex};
                GRS_WOFF_X: rd_mux = woff_x;
                GRS_WOFF_Y: rd_mux = woff_y;
                GRS_PW_LOW: rd_mux = win_min;
                GRS_PW_HIGH: rd_mux = win_max;
                GRS_XCLIP: rd_mux = {24'h00_0000, xclip};
                GRS_YCLIP: rd_mux = {24'h00_0000, yclip};
                GRS_HV_LESS: rd_mux = {28'h000_0000, hv_less};
                GRS_HV_GREATER: rd_mux = {28'h000_0000, hv_greater};
                GRS_VV_LESS: rd_mux = {28'h000_0000, vv_less};
                GRS_VV_GREATER: rd_mux = {28'h000_0000, vv_greater};
                GRS_PMASK: rd_mux = pmask;
                GRS_DRAW_CTL: rd_mux = draw_ctl;
                GRS_TILE_X: rd_mux = tile_x;
                GRS_TILE_Y: rd_mux = tile_y;
                GRS_BYTE_PIX: rd_mux = byte_pixel_leftover;
                GRS_WIN_MIN: rd_mux = win_min;
                GRS_WIN_MAX: rd_mux = win_max;
                GRS_RASTER: rd_mux = raster;
                default: rd_mux = GRS_ZERO;
            endcase
        end
    end

    // reset group next values
    always_comb begin
        next_sysconfig = sysconfig;
        next_int_en = int_en;
        next_int_flag = int_flag;
        if (hst_wr_i && hst_addr_i == GRS_SYSCONFIG) begin
            next_sysconfig = hst_wdata_i;
        end
        if (hst_wr_i && hst_addr_i == GRS_INT_EN) begin
            next_int_en = hst_wdata_i[IRQ_W-1:0];
        end
        // write one to clear; a new event beats the clear
        if (hst_wr_i && hst_addr_i == GRS_INT_FLAG) begin
            next_int_flag = int_flag & ~hst_wdata_i[IRQ_W-1:0];
        end
        next_int_flag = next_int_flag | int_event_i;
        // a mode change clears the interrupt state but not sysconfig
        if (mode_change_i) begin
            next_int_flag = GRS_INT_RST[IRQ_W-1:0];
            next_int_en = GRS_INT_RST[IRQ_W-1:0];
        end
        next_irq = |(int_flag & int_en);
        next_rd_valid = hst_rd_i;
        next_rd_data = hst_rd_i ? rd_mux : rd_data;
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sysconfig <= GRS_SYSCONFIG_RST;
            int_flag <= GRS_INT_RST[IRQ_W-1:0];
            int_en <= GRS_INT_RST[IRQ_W-1:0];
            rd_data <= GRS_ZERO;
            rd_valid <= 1'b0;
            irq <= 1'b0;
        end else begin
            sysconfig <= next_sysconfig;
            int_flag <= next_int_flag;
            int_en <= next_int_en;
            rd_data <= next_rd_data;
            rd_valid <= next_rd_valid;
            irq <= next_irq;
        end
    end

    // drawing state next values; read-only indices have no write path
    always_comb begin
        next_coord = coord;
        next_color = color;
        next_pmask = pmask;
        next_draw_ctl = draw_ctl;
        next_tile_x = tile_x;
        next_tile_y = tile_y;
        next_byte_pixel_leftover = byte_pixel_leftover;
        next_win_min = win_min;
        next_win_max = win_max;
        next_woff_x = woff_x;
        next_woff_y = woff_y;
        next_raster = raster;
        next_cindex = cindex;
        if (hst_wr_i) begin
            if (coord_hit) begin
                next_coord[coord_off[2:0]] = hst_wdata_i;
                next_cindex = coord_off[2:1];
            end else if (color_hit) begin
                next_color[color_off[1:0]] = hst_wdata_i;
            end else begin
                case (hst_addr_i)
                    GRS_CINDEX: next_cindex = hst_wdata_i[1:0];
                    GRS_WOFF_X: next_woff_x = hst_wdata_i;
                    GRS_WOFF_Y: next_woff_y = hst_wdata_i;
                    GRS_PMASK: next_pmask = hst_wdata_i;
                    GRS_DRAW_CTL: next_draw_ctl = hst_wdata_i;
                    GRS_TILE_X: next_tile_x = hst_wdata_i;
                    GRS_TILE_Y: next_tile_y = hst_wdata_i;
                    GRS_BYTE_PIX: next_byte_pixel_leftover = hst_wdata_i;
                    GRS_WIN_MIN: next_win_min = hst_wdata_i;
                    GRS_WIN_MAX: next_win_max = hst_wdata_i;
                    GRS_RASTER: next_raster = hst_wdata_i;
                    default: next_raster = raster;
                endcase
            end
        end
        // the engine's leftover bits win over a host write in the same cycle
        if (pix_load_i) begin
            next_byte_pixel_leftover = pix_data_i;
        end
    end

    // no reset here on purpose: drawing state survives a host reset
    always_ff @(posedge sys_clk_i) begin
        coord <= next_coord;
        color <= next_color;
        pmask <= next_pmask;
        draw_ctl <= next_draw_ctl;
        tile_x <= next_tile_x;
        tile_y <= next_tile_y;
        byte_pixel_leftover <= next_byte_pixel_leftover;
        win_min <= next_win_min;
        win_max <= next_win_max;
        woff_x <= next_woff_x;
        woff_y <= next_woff_y;
        raster <= next_raster;
        cindex <= next_cindex;
        // check results lag the coordinates by one cycle
        oor <= chk_if.oor;
        xclip <= chk_if.xclip;
        yclip <= chk_if.yclip;
        hv_less <= chk_if.hv_less;
        hv_greater <= chk_if.hv_greater;
        vv_less <= chk_if.vv_less;
        vv_greater <= chk_if.vv_greater;
        busy <= engine_busy_i;
    end

    assign hst_rdata_o = rd_data;
    assign hst_rvalid_o = rd_valid;
    assign irq_o = irq;
    assign sysconfig_o = sysconfig;
    assign pmask_o = pmask;
    assign draw_ctl_o = draw_ctl;
    assign cindex_o = cindex;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    a_sysconfig_write: assert property (
        hst_wr_i && hst_addr_i == GRS_SYSCONFIG |=> sysconfig_o == $past(hst_wdata_i))
        else $error("sysconfig write not stored");

    a_int_event_set: assert property (
        !mode_change_i && |int_event_i |=> (int_flag & $past(int_event_i)) == $past(int_event_i))
        else $error("interrupt event lost");

    a_irq_gating: assert property (
        ##1 irq_o == |($past(int_flag) & $past(int_en)))
        else $error("interrupt output not gated by enable");

    a_coord_store: assert property (
        hst_wr_i && coord_hit |=> coord[$past(coord_off[2:0])] == $past(hst_wdata_i))
        else $error("coordinate write not stored");

    a_cindex_track: assert property (
        hst_wr_i && coord_hit |=> cindex_o == $past(coord_off[2:1]))
        else $error("index does not follow coordinate write");

    a_window_mirror: assert property (
        hst_rd_i && hst_addr_i == GRS_PW_HIGH |=> hst_rvalid_o && hst_rdata_o == $past(win_max))
        else $error("window copy differs from window maximum");

    a_pmask_readback: assert property (
        hst_wr_i && hst_addr_i == GRS_PMASK ##1 hst_rd_i && hst_addr_i == GRS_PMASK
        |=> hst_rdata_o == $past(hst_wdata_i, 2))
        else $error("plane mask read back wrong");

    a_ro_write_ignored: assert property (
        hst_wr_i && hst_addr_i >= GRS_STATUS && hst_addr_i <= GRS_VV_GREATER
        && hst_addr_i != GRS_CINDEX && hst_addr_i != GRS_WOFF_X && hst_addr_i != GRS_WOFF_Y
        && !pix_load_i |=> $stable(win_min) && $stable(win_max) && $stable(pmask)
        && $stable(byte_pixel_leftover))
        else $error("write to read-only register changed state");

    a_mode_clear: assert property (
        mode_change_i |=> !(|int_flag) && !(|int_en))
        else $error("mode change left interrupt state set");

    a_leftover_load: assert property (
        pix_load_i |=> byte_pixel_leftover == $past(pix_data_i))
        else $error("leftover word not loaded by engine");

    a_rvalid_pulse: assert property (
        ##1 hst_rvalid_o == $past(hst_rd_i))
        else $error("read valid not one cycle after read strobe");

    a_status_busy: assert property (
        ##1 status_word[GRS_ST_BUSY] == $past(engine_busy_i))
        else $error("status busy bit not tracking engine");
endmodule // grs_regs

// ### testbench/tb_top.sv
// self-checking bench for the graphics register set, with a register model
`timescale 1ns/100ps
module tb_top;
    import grs_pkg::*;
    localparam int LIMIT = 20000;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic hst_wr_i = 1'b0;
    logic hst_rd_i = 1'b0;
    logic [5:0] hst_addr_i = 6'h00;
    logic [31:0] hst_wdata_i = 32'h0000_0000;
    logic mode_change_i = 1'b0;
    logic engine_busy_i = 1'b0;
    logic [7:0] int_event_i = 8'h00;
    logic pix_load_i = 1'b0;
    logic [31:0] pix_data_i = 32'h0000_0000;
    logic [31:0] hst_rdata_o, sysconfig_o, pmask_o, draw_ctl_o;
    logic hst_rvalid_o, irq_o;
    logic [1:0] cindex_o;
    logic [31:0] mreg [64];
    logic [7:0] mflag, men;
    logic [31:0] seed = 32'h0000_EC0D;
    logic [31:0] v;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    grs_regs #(.IRQ_W(GRS_IRQ_W)) i_dut (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .hst_wr_i(hst_wr_i), .hst_rd_i(hst_rd_i),
        .hst_addr_i(hst_addr_i), .hst_wdata_i(hst_wdata_i), .hst_rdata_o(hst_rdata_o),
        .hst_rvalid_o(hst_rvalid_o), .mode_change_i(mode_change_i),
        .engine_busy_i(engine_busy_i), .int_event_i(int_event_i), .pix_load_i(pix_load_i),
        .pix_data_i(pix_data_i), .irq_o(irq_o), .sysconfig_o(sysconfig_o),
        .pmask_o(pmask_o), .draw_ctl_o(draw_ctl_o), .cindex_o(cindex_o)
    );

    initial begin
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    task automatic results;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // a hang is cut short here and counted as a mismatch
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            errors++;
            results();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    function automatic bit is_rw(input logic [5:0] a);
        return a == 6'h00 || (a >= 6'h03 && a <= 6'h0A) || (a >= 6'h0D && a <= 6'h0F) ||
               (a >= 6'h18 && a <= 6'h23);
    endfunction

    // derived read-only words, worked out from the model contents
    function automatic logic [31:0] ro_val(input logic [5:0] a);
        logic [31:0] xc, yc, oo, hl, hg, vl, vg;
        logic signed [15:0] x0, y0, x1, y1;
        {xc, yc, oo, hl, hg, vl, vg} = '0;
        for (int n = 0; n < 4; n++) begin
            x0 = mreg[3 + 2 * n][15:0];
            y0 = mreg[4 + 2 * n][15:0];
            x1 = mreg[3 + 2 * ((n + 1) % 4)][15:0];
            y1 = mreg[4 + 2 * ((n + 1) % 4)][15:0];
            xc[2 * n] = x0 < $signed(mreg[GRS_WIN_MIN][31:16]);
            xc[2 * n + 1] = x0 > $signed(mreg[GRS_WIN_MAX][31:16]);
            yc[2 * n] = y0 < $signed(mreg[GRS_WIN_MIN][15:0]);
            yc[2 * n + 1] = y0 > $signed(mreg[GRS_WIN_MAX][15:0]);
            oo[2 * n] = !(&mreg[3 + 2 * n][31:15] || ~|mreg[3 + 2 * n][31:15]);
            oo[2 * n + 1] = !(&mreg[4 + 2 * n][31:15] || ~|mreg[4 + 2 * n][31:15]);
            hl[n] = x0 < x1;
            hg[n] = x0 > x1;
            vl[n] = y0 < y1;
            vg[n] = y0 > y1;
        end
        case (a)
            GRS_STATUS: return {28'h0, |oo, |yc, |xc, engine_busy_i};
            GRS_OOR: return oo;
            GRS_PW_LOW: return mreg[GRS_WIN_MIN];
            GRS_PW_HIGH: return mreg[GRS_WIN_MAX];
            GRS_XCLIP: return xc;
            GRS_YCLIP: return yc;
            GRS_HV_LESS: return hl;
            GRS_HV_GREATER: return hg;
            GRS_VV_LESS: return vl;
            GRS_VV_GREATER: return vg;
            default: return 32'h0000_0000;
        endcase
    endfunction

    function automatic logic [31:0] exp_rd(input logic [5:0] a);
        if (a == GRS_INT_FLAG) return {24'h0, mflag};
        if (a == GRS_INT_EN) return {24'h0, men};
        if (is_rw(a)) return mreg[a];
        return ro_val(a);
    endfunction

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        hst_wr_i <= 1'b1;
        hst_addr_i <= a;
        hst_wdata_i <= d;
        @(posedge sys_clk_i);
        hst_wr_i <= 1'b0;
        if (is_rw(a)) mreg[a] = d;
        if (a == GRS_CINDEX) mreg[a] = d & 32'h0000_0003;
        if (a >= GRS_COORD_BASE && a <= GRS_COORD_LAST) mreg[GRS_CINDEX] = 32'((a - 6'h03) >> 1);
        if (a == GRS_INT_FLAG) mflag = mflag & ~d[7:0];
        if (a == GRS_INT_EN) men = d[7:0];
    endtask

    task automatic rd_chk(input logic [5:0] a);
        logic [31:0] e;
        e = exp_rd(a);
        @(posedge sys_clk_i);
        hst_rd_i <= 1'b1;
        hst_addr_i <= a;
        @(posedge sys_clk_i);
        hst_rd_i <= 1'b0;
        #1;
        chk(hst_rvalid_o, 32'h1);
        chk(hst_rdata_o, e);
    endtask

    // event pulse; irq follows one edge after the event is taken
    task automatic ev(input logic [7:0] b);
        @(posedge sys_clk_i);
        int_event_i <= b;
        @(posedge sys_clk_i);
        int_event_i <= 8'h00;
        mflag = mflag | b;
        idle(1);
        chk(irq_o, |(mflag & men));
    endtask

    task automatic rst_model;
        mreg[GRS_SYSCONFIG] = GRS_SYSCONFIG_RST;
        mflag = GRS_INT_RST;
        men = GRS_INT_RST;
    endtask

    initial begin
        repeat (10) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rst_model();
        idle(1);
        chk(sysconfig_o, 32'h0);
        chk(irq_o, 32'h0);
        rd_chk(GRS_SYSCONFIG);
        rd_chk(GRS_INT_FLAG);
        rd_chk(GRS_INT_EN);
        // random fill of every index, read-only and unmapped ones included
        for (int r = 0; r < 3; r++) begin
            engine_busy_i <= r[0];
            for (int a = 0; a < 64; a++) begin
                v = rnd();
                wr(a[5:0], v);
            end
            idle(3);
            for (int a = 0; a < 64; a++) rd_chk(a[5:0]);
            chk(sysconfig_o, mreg[GRS_SYSCONFIG]);
            chk(pmask_o, mreg[GRS_PMASK]);
            chk(draw_ctl_o, mreg[GRS_DRAW_CTL]);
            chk(cindex_o, mreg[GRS_CINDEX][1:0]);
        end
        // write then read of the plane mask on consecutive edges
        v = rnd();
        @(posedge sys_clk_i);
        hst_wr_i <= 1'b1;
        hst_addr_i <= GRS_PMASK;
        hst_wdata_i <= v;
        @(posedge sys_clk_i);
        hst_wr_i <= 1'b0;
        hst_rd_i <= 1'b1;
        mreg[GRS_PMASK] = v;
        @(posedge sys_clk_i);
        hst_rd_i <= 1'b0;
        #1;
        chk(hst_rdata_o, v);
        chk(pmask_o, v);
        // random words are nearly always out of range; put vertex 0 in range
        wr(GRS_COORD_BASE, 32'h0000_0010);
        wr(GRS_COORD_BASE + 6'h01, 32'hFFFF_FFF0);
        idle(2);
        rd_chk(GRS_OOR);
        rd_chk(GRS_STATUS);
        rd_chk(GRS_XCLIP);
        // interrupts: mask, clear, set-wins and mode change
        wr(GRS_INT_FLAG, 32'h0000_00FF);
        wr(GRS_INT_EN, 32'h0000_0005);
        ev(8'h02);
        rd_chk(GRS_INT_FLAG);
        ev(8'h01);
        wr(GRS_INT_EN, 32'h0000_0000);
        idle(2);
        chk(irq_o, 32'h0);
        wr(GRS_INT_EN, 32'h0000_00FF);
        idle(2);
        chk(irq_o, 32'h1);
        @(posedge sys_clk_i);
        hst_wr_i <= 1'b1;
        hst_addr_i <= GRS_INT_FLAG;
        hst_wdata_i <= 32'h0000_00FF;
        int_event_i <= 8'h04;
        @(posedge sys_clk_i);
        hst_wr_i <= 1'b0;
        int_event_i <= 8'h00;
        mflag = 8'h04;
        rd_chk(GRS_INT_FLAG);
        @(posedge sys_clk_i);
        mode_change_i <= 1'b1;
        @(posedge sys_clk_i);
        mode_change_i <= 1'b0;
        mflag = 8'h00;
        men = 8'h00;
        idle(2);
        chk(irq_o, 32'h0);
        rd_chk(GRS_INT_FLAG);
        rd_chk(GRS_INT_EN);
        for (int b = 0; b < 8; b++) begin
            wr(GRS_INT_EN, 32'h1 << b);
            ev(8'h01 << b);
            wr(GRS_INT_FLAG, 32'h1 << b);
            idle(2);
            chk(irq_o, 32'h0);
        end
        // engine load of the leftover word wins over a host write
        v = rnd();
        @(posedge sys_clk_i);
        pix_load_i <= 1'b1;
        pix_data_i <= v;
        hst_wr_i <= 1'b1;
        hst_addr_i <= GRS_BYTE_PIX;
        hst_wdata_i <= ~v;
        @(posedge sys_clk_i);
        pix_load_i <= 1'b0;
        hst_wr_i <= 1'b0;
        mreg[GRS_BYTE_PIX] = v;
        rd_chk(GRS_BYTE_PIX);
        // second reset: only system control words clear
        wr(GRS_INT_EN, 32'h0000_00FF);
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rst_model();
        idle(3);
        chk(sysconfig_o, 32'h0);
        for (int a = 0; a < 64; a++) rd_chk(a[5:0]);
        chk(pmask_o, mreg[GRS_PMASK]);
        results();
    end
endmodule // tb_top
